// File: common/ftr_pkg.sv
// Purpose: Shared constants for the tagged readout port and its host controller
// Assumes: Byte-wide register link, 5-bit source codes, three 16-bit words per entry
// Notes:   Helper functions here are used by both ends of the link
package ftr_pkg;
	// Device register map
	localparam logic [7:0] FTR_ADDR_TAG = 8'h78;
	localparam logic [7:0] FTR_ADDR_W0L = 8'h79;
	localparam logic [7:0] FTR_ADDR_W0H = 8'h7A;
	localparam logic [7:0] FTR_ADDR_W1L = 8'h7B;
	localparam logic [7:0] FTR_ADDR_W1H = 8'h7C;
	localparam logic [7:0] FTR_ADDR_W2L = 8'h7D;
	localparam logic [7:0] FTR_ADDR_W2H = 8'h7E;
	localparam logic [7:0] FTR_BYTE_RST = 8'h00;
	// Source codes
	localparam logic [4:0] FTR_SRC_GYRO     = 5'h01;
	localparam logic [4:0] FTR_SRC_ACCEL    = 5'h02;
	localparam logic [4:0] FTR_SRC_TEMP     = 5'h03;
	localparam logic [4:0] FTR_SRC_TSTAMP   = 5'h04;
	localparam logic [4:0] FTR_SRC_CFG_CHG  = 5'h05;
	localparam logic [4:0] FTR_SRC_ACC_T2   = 5'h06;
	localparam logic [4:0] FTR_SRC_ACC_T1   = 5'h07;
	localparam logic [4:0] FTR_SRC_ACC_2C   = 5'h08;
	localparam logic [4:0] FTR_SRC_ACC_3C   = 5'h09;
	localparam logic [4:0] FTR_SRC_GYR_T2   = 5'h0A;
	localparam logic [4:0] FTR_SRC_GYR_T1   = 5'h0B;
	localparam logic [4:0] FTR_SRC_GYR_2C   = 5'h0C;
	localparam logic [4:0] FTR_SRC_GYR_3C   = 5'h0D;
	localparam logic [4:0] FTR_SRC_HUB0     = 5'h0E;
	localparam logic [4:0] FTR_SRC_HUB3     = 5'h11;
	localparam logic [4:0] FTR_SRC_STEP     = 5'h12;
	localparam logic [4:0] FTR_SRC_HUB_NACK = 5'h19;
	// Field layout
	localparam int FTR_SRC_W      = 5;
	localparam int FTR_SLOT_W     = 2;
	localparam int FTR_WORD_W     = 16;
	localparam int FTR_ENTRY_W    = FTR_SRC_W + FTR_SLOT_W + 3 * FTR_WORD_W;
	localparam int FTR_TAG_SRC_LSB = 3;
	localparam int FTR_FIFO_DEPTH = 8;
	// Host controller register map and fields
	localparam logic [3:0] FTR_HOST_CTRL_OFS = 4'h0;
	localparam logic [3:0] FTR_HOST_STAT_OFS = 4'h4;
	localparam int FTR_CTRL_WDATA_LSB = 8;
	localparam int FTR_CTRL_WE_BIT    = 16;
	localparam int FTR_CTRL_GO_BIT    = 17;
	localparam int FTR_STAT_DONE_BIT  = 1;
	localparam int FTR_STAT_RDATA_LSB = 8;
	localparam int FTR_STAT_PAROK_BIT = 16;
	localparam int FTR_STAT_ASGN_BIT  = 17;
	localparam int FTR_STAT_SRC_LSB   = 18;

	// True for every source code that names a real entry kind
	function automatic logic ftr_code_assigned(input logic [4:0] code);
		ftr_code_assigned = ((code >= FTR_SRC_GYRO) && (code <= FTR_SRC_STEP)) || (code == FTR_SRC_HUB_NACK);
	endfunction

	// Parity over tag bits 7..1, even or odd
	function automatic logic ftr_parity(input logic [6:0] bits, input logic odd);
		ftr_parity = (^bits) ^ odd;
	endfunction
endpackage

// File: common/ftr_link_if.sv
// Purpose: Byte register link between host controller and readout port
// Assumes: Both ends on one clock; host holds a request until one ack pulse
// Notes:   No clocking block; the bench joins the two ends through this
`timescale 1ns/1ps
interface ftr_link_if;
	logic       req;   // Request held by host
	logic       we;    // Write when high
	logic [7:0] addr;  // Register address
	logic [7:0] wdata; // Write byte
	logic [7:0] rdata; // Read byte, valid with ack
	logic       ack;   // One-cycle answer

	modport device
	(
		input  req,
		input  we,
		input  addr,
		input  wdata,
		output rdata,
		output ack
	);

	modport host
	(
		output req,
		output we,
		output addr,
		output wdata,
		input  rdata,
		input  ack
	);
endinterface

// File: design/ftr_fifo.sv
// Purpose: Entry buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Head is shown ahead; pop takes effect at the edge
`timescale 1ns/1ps
module ftr_fifo
	import ftr_pkg::*;
#(
	parameter int WIDTH = FTR_ENTRY_W,
	parameter int DEPTH = FTR_FIFO_DEPTH
)
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   in_valid_i,
	output logic                        in_ready_o,
	input  wire logic [WIDTH-1:0]       in_data_i,
	output logic                        out_valid_o,
	input  wire logic                   out_ready_i,
	output logic [WIDTH-1:0]            out_data_o,
	output logic [$clog2(DEPTH):0]      count_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];   // Storage, not reset
	logic [AW:0]      wr_ptr_r;        // Write pointer with wrap bit
	logic [AW:0]      rd_ptr_r;        // Read pointer with wrap bit
	logic             push;
	logic             pop;

	// Full when pointers differ only in the wrap bit
	assign in_ready_o  = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
	assign out_valid_o = wr_ptr_r != rd_ptr_r;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_ready_i & out_valid_o;
	assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];
	assign count_o     = wr_ptr_r - rd_ptr_r;

	// Storage write; no reset keeps it a plain RAM
	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
		end
	end

	// Pointer update
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
			rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
		end
	end
endmodule

// File: design/ftr_device.sv
// Purpose: Readout port of the batching buffer: tag byte plus three 16-bit words
// Assumes: Host follows the link handshake; entries arrive on a valid/ready port
// Notes:   The buffer advances only when the last data byte is read
`timescale 1ns/1ps

module ftr_device
	import ftr_pkg::*;
#(
	parameter bit PARITY_ODD = 1'b0,
	parameter int DEPTH      = FTR_FIFO_DEPTH
)
(
	input  wire logic                   CLK_I,
	input  wire logic                   SYS_RST_I,
	ftr_link_if.device                  LINK,
	input  wire logic                   ENTRY_VALID_I,
	output logic                        ENTRY_READY_O,
	input  wire logic [FTR_SRC_W-1:0]   ENTRY_SOURCE_I,
	input  wire logic [FTR_WORD_W-1:0]  ENTRY_WORD0_I,
	input  wire logic [FTR_WORD_W-1:0]  ENTRY_WORD1_I,
	input  wire logic [FTR_WORD_W-1:0]  ENTRY_WORD2_I,
	input  wire logic                   SLOT_TICK_I,
	output logic [FTR_SLOT_W-1:0]       SLOT_COUNT_O,
	output logic                        ENTRY_REJECT_O,
	output logic                        ENTRY_PENDING_O,
	output logic [$clog2(DEPTH):0]      FILL_LEVEL_O
);
	logic [FTR_SLOT_W-1:0]  slot_cnt_r;   // Running time slot counter
	logic                   code_ok;      // Incoming code is assigned
	logic                   fifo_ready;   // Buffer has room
	logic                   push_valid;   // Offer to the buffer
	logic                   reject_r;     // Pulse for a dropped entry
	logic [FTR_ENTRY_W-1:0] in_entry;     // Packed incoming entry
	logic [FTR_ENTRY_W-1:0] head_entry;   // Packed head entry
	logic                   head_valid;   // Buffer not empty
	logic [FTR_SRC_W-1:0]   head_src;     // Head source code
	logic [FTR_SLOT_W-1:0]  head_slot;    // Head slot stamp
	logic [FTR_WORD_W-1:0]  head_w0;      // Head first word
	logic [FTR_WORD_W-1:0]  head_w1;      // Head second word
	logic [FTR_WORD_W-1:0]  head_w2;      // Head third word
	logic [7:0]             tag_byte;     // Tag as seen by the host
	logic                   take;         // Link request taken this cycle
	logic                   pop;          // Retire the head entry
	logic                   ack_r;        // Link answer
	logic [7:0]             rdata_r;      // Link read byte
	logic [7:0]             rdata_nxt;    // Byte selected by address

	// Slot counter wraps freely; it stamps each entry as it is stored
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			slot_cnt_r <= '0;
		end
		else if (SLOT_TICK_I)
		begin
			slot_cnt_r <= slot_cnt_r + 2'd1;
		end
	end

	assign SLOT_COUNT_O = slot_cnt_r;

	// Only assigned codes enter the buffer, so no stored entry shows the host a stray code
	assign code_ok    = ftr_code_assigned(ENTRY_SOURCE_I);
	assign push_valid = ENTRY_VALID_I & code_ok;
	// Ready follows room alone, so an unassigned entry is consumed and dropped
	assign ENTRY_READY_O = fifo_ready;
	assign in_entry = {ENTRY_SOURCE_I, slot_cnt_r, ENTRY_WORD2_I, ENTRY_WORD1_I, ENTRY_WORD0_I};

	// Reject pulse one cycle after a dropped entry
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			reject_r <= 1'b0;
		end
		else
		begin
			reject_r <= ENTRY_VALID_I & fifo_ready & ~code_ok;
		end
	end

	assign ENTRY_REJECT_O = reject_r;

	// Entry buffer
	ftr_fifo #(
		.WIDTH (FTR_ENTRY_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_i       (CLK_I),
		.rst_i       (SYS_RST_I),
		.in_valid_i  (push_valid),
		.in_ready_o  (fifo_ready),
		.in_data_i   (in_entry),
		.out_valid_o (head_valid),
		.out_ready_i (pop),
		.out_data_o  (head_entry),
		.count_o     (FILL_LEVEL_O)
	);

	assign ENTRY_PENDING_O = head_valid;

	// Unpack the head entry
	assign head_src  = head_entry[FTR_ENTRY_W-1 -: FTR_SRC_W];
	assign head_slot = head_entry[3*FTR_WORD_W +: FTR_SLOT_W];
	assign head_w2   = head_entry[2*FTR_WORD_W +: FTR_WORD_W];
	assign head_w1   = head_entry[FTR_WORD_W +: FTR_WORD_W];
	assign head_w0   = head_entry[0 +: FTR_WORD_W];

	// Tag assembly; an empty buffer shows all zero, which is an unassigned code
	always_comb
	begin
		tag_byte = FTR_BYTE_RST;
		if (head_valid)
		begin
			tag_byte[7:FTR_TAG_SRC_LSB] = head_src;
			tag_byte[2:1]               = head_slot;
			tag_byte[0]                 = ftr_parity({head_src, head_slot}, PARITY_ODD);
		end
	end

	// A request is taken once; the ack blocks a second take of the same hold
	assign take = LINK.req & ~ack_r;

	// Reading the final high byte retires the entry; tag or low bytes never do
	assign pop = take & ~LINK.we & (LINK.addr == FTR_ADDR_W2H) & head_valid;

	// Byte selection; unmapped addresses read zero
	always_comb
	begin
		case (LINK.addr)
			FTR_ADDR_TAG:
			begin
				rdata_nxt = tag_byte;
			end
			FTR_ADDR_W0L:
			begin
				rdata_nxt = head_valid ? head_w0[7:0] : FTR_BYTE_RST;
			end
			FTR_ADDR_W0H:
			begin
				rdata_nxt = head_valid ? head_w0[15:8] : FTR_BYTE_RST;
			end
			FTR_ADDR_W1L:
			begin
				rdata_nxt = head_valid ? head_w1[7:0] : FTR_BYTE_RST;
			end
			FTR_ADDR_W1H:
			begin
				rdata_nxt = head_valid ? head_w1[15:8] : FTR_BYTE_RST;
			end
			FTR_ADDR_W2L:
			begin
				rdata_nxt = head_valid ? head_w2[7:0] : FTR_BYTE_RST;
			end
			FTR_ADDR_W2H:
			begin
				rdata_nxt = head_valid ? head_w2[15:8] : FTR_BYTE_RST;
			end
			default:
			begin
				rdata_nxt = FTR_BYTE_RST;
			end
		endcase
	end

	// Link answer: one ack per request, read data from flops
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			ack_r <= 1'b0;
		end
		else
		begin
			ack_r <= take;
		end
	end

	// Read byte is captured before the pop edge moves the head
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			rdata_r <= FTR_BYTE_RST;
		end
		else if (take & ~LINK.we)
		begin
			rdata_r <= rdata_nxt;
		end
		else if (take)
		begin
			// All registers here are read only, so a write is answered and dropped
			rdata_r <= FTR_BYTE_RST;
		end
	end

	assign LINK.ack   = ack_r;
	assign LINK.rdata = rdata_r;
endmodule

// File: design/ftr_host.sv
// Purpose: Host controller issuing byte accesses on the link from Wishbone orders
// Assumes: Classic Wishbone master, one access at a time
// Notes:   A read of the tag address also decodes the tag into status
`timescale 1ns/1ps
module ftr_host
	import ftr_pkg::*;
#(
	parameter bit PARITY_ODD = 1'b0
)
(
	input  wire logic        CLK_I,
	input  wire logic        SYS_RST_I,
	input  wire logic [3:0]  ADR_I,
	input  wire logic [31:0] DAT_I,
	output logic [31:0]      DAT_O,
	input  wire logic        WE_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	output logic             ACK_O,
	ftr_link_if.host         LINK
);
	typedef enum logic [0:0] {HS_IDLE = 1'b0, HS_WAIT = 1'b1} ftr_hstate_type;

	ftr_hstate_type st_r;        // Link sequencer state
	logic           wb_ack_r;    // Bus answer
	logic [31:0]    wb_dat_r;    // Bus read data
	logic           wr_fire;     // Bus write at the ack edge
	logic           go;          // Start order accepted
	logic           req_r;       // Link request
	logic           we_r;        // Link direction
	logic [7:0]     addr_r;      // Link address
	logic [7:0]     wdata_r;     // Link write byte
	logic [7:0]     rdata_r;     // Last read byte
	logic [7:0]     tag_r;       // Last tag byte read
	logic           done_r;      // Sticky completion
	logic [31:0]    stat;        // Status word

	assign wr_fire = CYC_I & STB_I & WE_I & wb_ack_r & (ADR_I == FTR_HOST_CTRL_OFS);
	// Start is ignored while busy, so orders cannot overlap on the link
	assign go = wr_fire & SEL_I[2] & DAT_I[FTR_CTRL_GO_BIT] & (st_r == HS_IDLE);

	// Link sequencer: hold request until the single ack
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			st_r    <= HS_IDLE;
			req_r   <= 1'b0;
			we_r    <= 1'b0;
			addr_r  <= FTR_BYTE_RST;
			wdata_r <= FTR_BYTE_RST;
		end
		else
		begin
			case (st_r)
				HS_IDLE:
				begin
					if (go)
					begin
						st_r    <= HS_WAIT;
						req_r   <= 1'b1;
						we_r    <= DAT_I[FTR_CTRL_WE_BIT];
						addr_r  <= DAT_I[7:0];
						wdata_r <= DAT_I[FTR_CTRL_WDATA_LSB +: 8];
					end
				end
				HS_WAIT:
				begin
					if (LINK.ack)
					begin
						st_r  <= HS_IDLE;
						req_r <= 1'b0;
					end
				end
				default:
				begin
					st_r  <= HS_IDLE;
					req_r <= 1'b0;
				end
			endcase
		end
	end

	// Result capture; tag reads are kept for decode
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			rdata_r <= FTR_BYTE_RST;
			tag_r   <= FTR_BYTE_RST;
			done_r  <= 1'b0;
		end
		else if ((st_r == HS_WAIT) && LINK.ack)
		begin
			done_r <= 1'b1;
			if (!we_r)
			begin
				rdata_r <= LINK.rdata;
				if (addr_r == FTR_ADDR_TAG)
				begin
					tag_r <= LINK.rdata;
				end
			end
		end
		else if (go)
		begin
			done_r <= 1'b0;
		end
	end

	// Status: parity check and code class of the last tag
	always_comb
	begin
		stat = '0;
		stat[0] = (st_r == HS_WAIT);
		stat[FTR_STAT_DONE_BIT] = done_r;
		stat[FTR_STAT_RDATA_LSB +: 8] = rdata_r;
		stat[FTR_STAT_PAROK_BIT] = ftr_parity(tag_r[7:1], PARITY_ODD) == tag_r[0];
		stat[FTR_STAT_ASGN_BIT] = ftr_code_assigned(tag_r[7:3]);
		stat[FTR_STAT_SRC_LSB +: FTR_SRC_W] = tag_r[7:3];
	end

	// Bus slave: ack one cycle after strobe, unmapped reads zero
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			wb_ack_r <= 1'b0;
			wb_dat_r <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_r <= CYC_I & STB_I & ~wb_ack_r;
			if (CYC_I & STB_I & ~wb_ack_r)
			begin
				wb_dat_r <= (ADR_I == FTR_HOST_STAT_OFS) ? stat : 32'h0000_0000;
			end
		end
	end

	assign ACK_O      = wb_ack_r;
	assign DAT_O      = wb_dat_r;
	assign LINK.req   = req_r;
	assign LINK.we    = we_r;
	assign LINK.addr  = addr_r;
	assign LINK.wdata = wdata_r;
endmodule

// File: testbench/ftr_link_properties.sv
// Purpose: Timing and content checks on the byte link between both ends
// Assumes: One clock, asynchronous active-high reset
// Notes:   Sees only link wires; buffer order is judged by the bench
`timescale 1ns/1ps
module ftr_link_properties
#(
	parameter bit PARITY_ODD = 1'b0
)
(
	input  wire logic       CLK_I,
	input  wire logic       SYS_RST_I,
	input  wire logic       req,
	input  wire logic       we,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] rdata,
	input  wire logic       ack
);
	// Read answers; an empty buffer shows a zero tag, so that one is skipped
	wire rd_ack = ack && !we;
	wire tag_rd = rd_ack && (addr == 8'h78) && (rdata != 8'h00);

	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	ack_latency_a: assert property (req && !ack |=> ack) else $error("link answer late");
	ack_pulse_a: assert property (ack |=> !ack) else $error("link answer longer than one cycle");
	ack_cause_a: assert property (ack |-> $past(req)) else $error("link answer without request");
	req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(we))
		else $error("request moved");
	req_release_a: assert property (ack |=> !req) else $error("request kept after answer");
	write_ignored_a: assert property (ack && we |-> rdata == 8'h00)
		else $error("write answered with data");
	unmapped_zero_a: assert property (rd_ack && (addr < 8'h78 || addr > 8'h7E) |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	tag_parity_a: assert property (tag_rd |-> (^rdata) == PARITY_ODD)
		else $error("tag parity wrong");
	tag_code_a: assert property (tag_rd |-> rdata[7:3] inside {[5'h01:5'h12], 5'h19})
		else $error("tag code unassigned");
	rdata_hold_a: assert property (!ack |-> $stable(rdata))
		else $error("read byte moved between answers");
endmodule

// File: testbench/fifo_tagged_readout_port_tb.sv
// Purpose: Self-checking bench joining host controller and readout port
// Assumes: Host reached over classic Wishbone; entries pushed on the device port
// Notes:   Buffer filled to refusal and drained in rounds; odd parity on purpose
`timescale 1ns/1ps
module fifo_tagged_readout_port_tb
	import ftr_pkg::*;
;
	localparam bit PAR_ODD = 1'b1; // Non-default polarity is the awkward case

	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic [3:0]  adr     = 4'h0;
	logic [31:0] dat_w   = 32'h0000_0000;
	logic        wb_we   = 1'b0;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic [3:0]  sel     = 4'h0;
	logic        e_valid = 1'b0;
	logic [4:0]  e_src   = 5'h00;
	logic [15:0] e_w0    = 16'h0000;
	logic [15:0] e_w1    = 16'h0000;
	logic [15:0] e_w2    = 16'h0000;
	logic        tick    = 1'b0;
	wire  [31:0] dat_r;
	wire         ack;
	wire         e_ready;
	wire  [1:0]  slot;
	wire         rej_o;
	wire         pend;
	wire  [3:0]  fill;
	int          seed       = 36;
	int          fail_count = 0;
	int          n_compared = 0;
	logic [1:0]  slot_m     = 2'd0;  // Expected slot counter
	logic [54:0] exp_q[$];           // Expected {source, slot, words}
	logic [4:0]  bad[5] = '{5'h00, 5'h13, 5'h18, 5'h1A, 5'h1F};

	// Free-running clock, 100 ns period
	always #50 clk = ~clk;

	ftr_link_if i_ftr_link_if ();

	ftr_device #(.PARITY_ODD(PAR_ODD), .DEPTH(8)) i_ftr_device
	(
		.CLK_I           (clk),
		.SYS_RST_I       (rst),
		.LINK            (i_ftr_link_if),
		.ENTRY_VALID_I   (e_valid),
		.ENTRY_READY_O   (e_ready),
		.ENTRY_SOURCE_I  (e_src),
		.ENTRY_WORD0_I   (e_w0),
		.ENTRY_WORD1_I   (e_w1),
		.ENTRY_WORD2_I   (e_w2),
		.SLOT_TICK_I     (tick),
		.SLOT_COUNT_O    (slot),
		.ENTRY_REJECT_O  (rej_o),
		.ENTRY_PENDING_O (pend),
		.FILL_LEVEL_O    (fill)
	);

	ftr_host #(.PARITY_ODD(PAR_ODD)) i_ftr_host
	(
		.CLK_I     (clk),
		.SYS_RST_I (rst),
		.ADR_I     (adr),
		.DAT_I     (dat_w),
		.DAT_O     (dat_r),
		.WE_I      (wb_we),
		.SEL_I     (sel),
		.CYC_I     (cyc),
		.STB_I     (stb),
		.ACK_O     (ack),
		.LINK      (i_ftr_link_if)
	);

	ftr_link_properties #(.PARITY_ODD(PAR_ODD)) i_ftr_link_properties
	(
		.CLK_I     (clk),
		.SYS_RST_I (rst),
		.req       (i_ftr_link_if.req),
		.we        (i_ftr_link_if.we),
		.addr      (i_ftr_link_if.addr),
		.rdata     (i_ftr_link_if.rdata),
		.ack       (i_ftr_link_if.ack)
	);

	// Assigned codes in table order, wrapping
	function automatic logic [4:0] code_of(input int i);
		code_of = (i % 19 < 18) ? 5'(i % 19 + 1) : 5'h19;
	endfunction

	// Tag byte the device should show
	function automatic logic [7:0] tag_of(input logic [4:0] s, input logic [1:0] c);
		tag_of = {s, c, (^{s, c}) ^ PAR_ODD};
	endfunction

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// One classic Wishbone cycle; waits as long as the slave needs
	task automatic wb_cycle(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		adr <= a;
		wb_we <= w;
		dat_w <= d;
		sel <= 4'hF;
		cyc <= 1'b1;
		stb <= 1'b1;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		wb_we <= 1'b0;
		sel <= 4'h0;
		@(posedge clk);
	endtask

	// One link byte access through the host, then poll until done
	task automatic link_op(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] st);
		logic [31:0] q;
		wb_cycle(FTR_HOST_CTRL_OFS, 1'b1, {14'h0, 1'b1, w, d, a}, q);
		do
			wb_cycle(FTR_HOST_STAT_OFS, 1'b0, 32'h0000_0000, st);
		while (st[FTR_STAT_DONE_BIT] !== 1'b1);
	endtask

	// Offer one entry with random words; kept entries join the expected queue
	task automatic push(input logic [4:0] src, input logic keep, output logic rej);
		logic [47:0] w;
		w = 48'({$random(seed), $random(seed)});
		e_valid <= 1'b1;
		e_src <= src;
		{e_w2, e_w1, e_w0} <= w;
		@(posedge clk);
		e_valid <= 1'b0;
		if (keep)
			exp_q.push_back({src, slot_m, w});
		@(posedge clk);
		rej = rej_o;
	endtask

	task automatic do_tick();
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		slot_m = slot_m + 2'd1;
		// The counter moves in the tick edge's update, so it is read one edge later
		@(posedge clk);
	endtask

	// Hang guard, far beyond the few thousand cycles the run needs
	initial
	begin
		repeat (40000) @(posedge clk);
		fail_count++;
		end_sim();
	end

	initial
	begin
		logic [31:0] st;
		logic        r;
		logic [54:0] e;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("level after reset", 32'h0000_0000, 32'({pend, slot, fill}));
		link_op(1'b0, FTR_ADDR_TAG, 8'h00, st);
		check("empty tag", 32'h0000_0000, 32'(st[15:8]));
		link_op(1'b0, 8'h7F, 8'h00, st);
		check("unmapped byte", 32'h0000_0000, 32'(st[15:8]));
		wb_cycle(4'h8, 1'b0, 32'h0000_0000, st);
		check("unmapped host word", 32'h0000_0000, st);
		// Unassigned codes are dropped with a pulse
		foreach (bad[i])
		begin
			push(bad[i], 1'b0, r);
			check("reject", 32'h0000_0001, 32'(r));
			check("level after reject", 32'h0000_0000, 32'(fill));
		end
		for (int rnd = 0; rnd < 3; rnd++)
		begin
			// Fill to refusal, stepping the slot counter through its wrap
			for (int k = 0; k < 8; k++)
			begin
				repeat ($random(seed) & 3) do_tick();
				check("slot", 32'(slot_m), 32'(slot));
				push(code_of(rnd * 8 + k), 1'b1, r);
				check("no reject", 32'h0000_0000, 32'(r));
			end
			check("full", 32'h0000_0008, 32'({e_ready, fill}));
			// Drain, with a write to the tag first and a check that only the last byte pops
			for (int k = 0; k < 8; k++)
			begin
				e = exp_q.pop_front();
				link_op(1'b1, FTR_ADDR_TAG, 8'($random(seed)), st);
				link_op(1'b0, FTR_ADDR_TAG, 8'h00, st);
				check("tag", 32'(tag_of(e[54:50], e[49:48])), 32'(st[15:8]));
				check("tag decode", 32'({e[54:50], 2'b11}), 32'(st[22:16]));
				for (int a = 1; a < 7; a++)
				begin
					if (a == 6)
						check("level before pop", 32'(exp_q.size() + 1), 32'(fill));
					link_op(1'b0, 8'(FTR_ADDR_TAG + a), 8'h00, st);
					check("data byte", 32'(e[(a - 1) * 8 +: 8]), 32'(st[15:8]));
				end
			end
			check("drained", 32'h0000_0000, 32'({pend, fill}));
		end
		// Reset in mid-run, with an entry stored and the slot counter moved on
		do_tick();
		push(FTR_SRC_STEP, 1'b0, r);
		check("no reject", 32'h0000_0000, 32'(r));
		check("held before reset", 32'({1'b1, slot_m, 4'h1}), 32'({pend, slot, fill}));
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		slot_m = 2'd0;
		@(posedge clk);
		check("level after mid reset", 32'h0000_0000, 32'({pend, slot, fill}));
		// A last-byte read of an empty buffer answers zero and must not pop
		link_op(1'b0, FTR_ADDR_W2H, 8'h00, st);
		check("empty last byte", 32'h0000_0000, 32'(st[15:8]));
		check("empty read keeps level", 32'h0000_0000, 32'({pend, fill}));
		end_sim();
	end
endmodule
